// ==== src/adsc_pkg.sv ====
// constants and types for the audio dac sound control register bank
// assumes one clock domain shared with the serial control decoder
// How it works
// - bass lift decoded per feature mode, capped
// - bit 15 picks soft or quick silence
// - silence request mutes; resets to one
// - gain select gives 0 or 6 dB
// - emphasis field selects none, 32, 44.1, 48
// - emphasis field only in modes 4-8; auto 1,3
// - sign flip inverts output samples when set
// - rate range bit selects tracking band
// - source field picks data, clock, pll reference
// - feature mode selects flat, minimum, maximum tables
// - slicer bit picks input a or b
// - burst enable mutes on compressed preambles
// - combine bit folds pcm detect into lock
package adsc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int SAMPLE_W = 24;

    localparam logic [ADDR_W-1:0] SOUND_FEATURE_OFS = 8'h12;
    localparam logic [ADDR_W-1:0] DEEMPHASIS_MUTE_CTRL_OFS = 8'h13;
    localparam logic [ADDR_W-1:0] DAC_SOURCE_CLOCK_CTRL_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] SPDIF_INPUT_CTRL_OFS = 8'h30;

    // sound feature register fields
    localparam int FEATURE_MODE_LSB = 14;
    localparam int LOW_FREQ_LIFT_LSB = 8;
    // de-emphasis and mute register fields
    localparam int FAST_SILENCE_BIT = 15;
    localparam int SILENCE_REQUEST_BIT = 14;
    localparam int PATH_GAIN_BIT = 13;
    localparam int EMPHASIS_LSB = 8;
    // dac source register fields
    localparam int SIGN_FLIP_BIT = 15;
    localparam int RATE_RANGE_BIT = 14;
    localparam int SOURCE_LSB = 8;
    // spdif input register fields
    localparam int PCM_COMBINE_BIT = 3;
    localparam int BURST_SILENCE_BIT = 2;
    localparam int INPUT_PICK_BIT = 0;

    localparam logic [1:0] FEATURE_MODE_RST = 2'h0;
    localparam logic [3:0] LOW_FREQ_LIFT_RST = 4'h0;
    localparam logic FAST_SILENCE_RST = 1'b0;
    localparam logic SILENCE_REQUEST_RST = 1'b1;
    localparam logic PATH_GAIN_RST = 1'b0;
    localparam logic [2:0] EMPHASIS_RST = 3'h0;
    localparam logic SIGN_FLIP_RST = 1'b0;
    localparam logic RATE_RANGE_RST = 1'b1;
    localparam logic [1:0] SOURCE_RST = 2'h2;
    localparam logic PCM_COMBINE_RST = 1'b1;
    localparam logic BURST_SILENCE_RST = 1'b1;
    localparam logic INPUT_PICK_RST = 1'b0;

    // bass lift ceilings in dB
    localparam logic [4:0] LIFT_CAP_MIN_DB = 5'h12;
    localparam logic [4:0] LIFT_CAP_MAX_DB = 5'h18;

    typedef enum logic [1:0] {
        ADSC_FLAT = 2'h0,
        ADSC_MINIMUM = 2'h1,
        ADSC_UNUSED = 2'h2,
        ADSC_MAXIMUM = 2'h3
    } adsc_feature_t;

    typedef enum logic [1:0] {
        ADSC_SRC_SERIAL_SPDIF_REF = 2'h0,
        ADSC_SRC_SERIAL_WS_REF = 2'h1,
        ADSC_SRC_SPDIF = 2'h2,
        ADSC_SRC_SERIAL_XTAL = 2'h3
    } adsc_source_t;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } adsc_wr_t;

    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] data;
    } adsc_sample_t;

    // decoded controls shown to the signal path
    typedef struct packed {
        logic [4:0] bass_lift_db;
        logic fast_silence;
        logic silence_active;
        logic gain_6db;
        logic [2:0] emphasis_curve;
        logic emphasis_auto;
        logic rate_high;
        logic rate_narrow;
        logic data_from_spdif;
        logic clock_from_xtal;
        logic pll_ref_word_select;
        logic input_b;
        logic lock;
    } adsc_ctrl_t;

endpackage

// ==== src/adsc_regs.sv ====
// register bank and decode for the dac sound control group
// assumes writes arrive already decoded from the serial control port, same clock
`timescale 1ns/1ps

module adsc_regs (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire adsc_pkg::adsc_wr_t wr_in,
    input wire logic [3:0] op_mode_in,
    input wire logic silence_pin_in,
    input wire logic burst_detect_in,
    input wire logic spdif_lock_in,
    input wire logic pcm_detect_in,
    input wire adsc_pkg::adsc_sample_t sample_in,
    output logic [1:0] sound_mode_out,
    output adsc_pkg::adsc_ctrl_t ctrl_out,
    output adsc_pkg::adsc_sample_t sample_out
);
    import adsc_pkg::*;

    typedef struct packed {
        adsc_feature_t mode;
        logic [3:0] low_freq_lift;
        logic fast_silence_select;
        logic silence_request;
        logic path_gain_select;
        logic [2:0] emphasis_curve_select;
        logic output_sign_flip;
        logic rate_range_select;
        adsc_source_t source;
        logic pcm_combine;
        logic compressed_frame_auto_silence;
        logic optical_coax_input_pick;
        logic [1:0] pin_sync;
        adsc_ctrl_t ctrl;
        adsc_sample_t sample;
    } adsc_state_t;

    adsc_state_t s_q;
    adsc_state_t s_d;
    logic [4:0] lift_x2;

    always_comb begin
        s_d = s_q;
        lift_x2 = {s_q.low_freq_lift, 1'b0};
        // mute pin comes from outside: two stages before use
        s_d.pin_sync = {s_q.pin_sync[0], silence_pin_in};
        if (wr_in.en) begin
            // reserved bits are dropped; host zeroes them except bits 13:12 of the 8'h12 register
            unique case (wr_in.addr)
                SOUND_FEATURE_OFS: begin
                    s_d.mode = adsc_feature_t'(wr_in.data[FEATURE_MODE_LSB +: 2]);
                    s_d.low_freq_lift = wr_in.data[LOW_FREQ_LIFT_LSB +: 4];
                end
                DEEMPHASIS_MUTE_CTRL_OFS: begin
                    s_d.fast_silence_select = wr_in.data[FAST_SILENCE_BIT];
                    s_d.silence_request = wr_in.data[SILENCE_REQUEST_BIT];
                    s_d.path_gain_select = wr_in.data[PATH_GAIN_BIT];
                    s_d.emphasis_curve_select = wr_in.data[EMPHASIS_LSB +: 3];
                end
                DAC_SOURCE_CLOCK_CTRL_OFS: begin
                    s_d.output_sign_flip = wr_in.data[SIGN_FLIP_BIT];
                    s_d.rate_range_select = wr_in.data[RATE_RANGE_BIT];
                    s_d.source = adsc_source_t'(wr_in.data[SOURCE_LSB +: 2]);
                end
                SPDIF_INPUT_CTRL_OFS: begin
                    s_d.pcm_combine = wr_in.data[PCM_COMBINE_BIT];
                    s_d.compressed_frame_auto_silence = wr_in.data[BURST_SILENCE_BIT];
                    s_d.optical_coax_input_pick = wr_in.data[INPUT_PICK_BIT];
                end
                default: begin
                    // other addresses belong to other banks
                end
            endcase
        end
        // decode from the stored settings; decoded outputs lag a write by two cycles
        unique case (s_q.mode)
            ADSC_MINIMUM: s_d.ctrl.bass_lift_db =
                (lift_x2 > LIFT_CAP_MIN_DB) ? LIFT_CAP_MIN_DB : lift_x2;
            ADSC_MAXIMUM: s_d.ctrl.bass_lift_db =
                (lift_x2 > LIFT_CAP_MAX_DB) ? LIFT_CAP_MAX_DB : lift_x2;
            // code 10 is undefined; treated as flat
            default: s_d.ctrl.bass_lift_db = 5'h00;
        endcase
        s_d.ctrl.fast_silence = s_q.fast_silence_select;
        s_d.ctrl.silence_active = s_q.silence_request | s_q.pin_sync[1]
            | (s_q.compressed_frame_auto_silence & burst_detect_in);
        s_d.ctrl.gain_6db = s_q.path_gain_select;
        s_d.ctrl.emphasis_auto = (op_mode_in == 4'h1) || (op_mode_in == 4'h3);
        s_d.ctrl.emphasis_curve = ((op_mode_in >= 4'h4) && (op_mode_in <= 4'h8))
            ? s_q.emphasis_curve_select : 3'h0;
        s_d.ctrl.rate_high = s_q.rate_range_select;
        s_d.ctrl.rate_narrow = ~s_q.rate_range_select
            & ((op_mode_in == 4'h6) || (op_mode_in == 4'h7));
        s_d.ctrl.data_from_spdif = (s_q.source == ADSC_SRC_SPDIF);
        s_d.ctrl.clock_from_xtal = (s_q.source == ADSC_SRC_SERIAL_XTAL);
        s_d.ctrl.pll_ref_word_select = (s_q.source == ADSC_SRC_SERIAL_WS_REF);
        s_d.ctrl.input_b = s_q.optical_coax_input_pick;
        s_d.ctrl.lock = spdif_lock_in & (~s_q.pcm_combine | pcm_detect_in);
        s_d.sample.valid = sample_in.valid;
        // two's complement negate wraps the most negative code to itself
        s_d.sample.data = s_q.output_sign_flip
            ? SAMPLE_W'(~sample_in.data + 1'b1) : sample_in.data;
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_q <= '0;
            s_q.mode <= adsc_feature_t'(FEATURE_MODE_RST);
            s_q.low_freq_lift <= LOW_FREQ_LIFT_RST;
            s_q.fast_silence_select <= FAST_SILENCE_RST;
            s_q.silence_request <= SILENCE_REQUEST_RST;
            s_q.path_gain_select <= PATH_GAIN_RST;
            s_q.emphasis_curve_select <= EMPHASIS_RST;
            s_q.output_sign_flip <= SIGN_FLIP_RST;
            s_q.rate_range_select <= RATE_RANGE_RST;
            s_q.source <= adsc_source_t'(SOURCE_RST);
            s_q.pcm_combine <= PCM_COMBINE_RST;
            s_q.compressed_frame_auto_silence <= BURST_SILENCE_RST;
            s_q.optical_coax_input_pick <= INPUT_PICK_RST;
            // outputs start muted and consistent with reset settings
            s_q.ctrl.silence_active <= SILENCE_REQUEST_RST;
            s_q.ctrl.rate_high <= RATE_RANGE_RST;
            s_q.ctrl.data_from_spdif <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign sound_mode_out = s_q.mode;
    assign ctrl_out = s_q.ctrl;
    assign sample_out = s_q.sample;

endmodule

// ==== tb/adsc_host.sv ====
// host model writing the sound control registers
// assumes the bank samples writes on the rising edge
`timescale 1ns/1ps
module adsc_host
    import adsc_pkg::*;
(
    input wire logic clock_in,
    output adsc_pkg::adsc_wr_t wr_out
);
    initial wr_out <= '0;
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] m;
        m = a == 8'h12 ? 16'hFF00 : a == 8'h13 ? 16'hE700 : 16'hFFFF;
        m = a == 8'h14 ? 16'hC300 : a == 8'h30 ? 16'h000D : m;
        @(posedge clock_in);
        #1;
        wr_out <= '{1'b1, a, d & m};
        @(posedge clock_in);
        #1;
        wr_out.en <= 1'b0;
    endtask
endmodule

// ==== tb/adsc_regs_chk.sv ====
// port assertions for the sound control register bank
// assumes it is bound to adsc_regs; one clock domain
`timescale 1ns/1ps
module adsc_regs_chk
    import adsc_pkg::*;
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire adsc_pkg::adsc_wr_t wr_in,
    input wire logic [3:0] op_mode_in,
    input wire logic silence_pin_in,
    input wire logic burst_detect_in,
    input wire logic spdif_lock_in,
    input wire logic pcm_detect_in,
    input wire adsc_pkg::adsc_sample_t sample_in,
    input wire logic [1:0] sound_mode_out,
    input wire adsc_pkg::adsc_ctrl_t ctrl_out,
    input wire adsc_pkg::adsc_sample_t sample_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    sequence wr13_s;
        wr_in.en && wr_in.addr == 8'h13;
    endsequence
    sequence wr12_s;
        wr_in.en && wr_in.addr == 8'h12;
    endsequence
    sequence idle2_s;
        !wr_in.en [*2];
    endsequence
    mute_write_a: assert property (wr13_s ##0 wr_in.data[14]
        |-> ##2 ctrl_out.silence_active)
        else $error("mute write left output live");
    gain_write_a: assert property (wr13_s ##1 idle2_s
        |-> ctrl_out.gain_6db == $past(wr_in.data[13], 2))
        else $error("gain flag differs from written bit");
    mode_write_a: assert property (wr12_s
        |=> sound_mode_out == $past(wr_in.data[15:14]))
        else $error("stored feature mode differs from written field");
    flat_lift_a: assert property ($past(sound_mode_out) inside {2'h0, 2'h2}
        |-> ctrl_out.bass_lift_db == 5'h0)
        else $error("bass lift nonzero in flat mode");
    min_cap_a: assert property ($past(sound_mode_out) == 2'h1
        |-> ctrl_out.bass_lift_db <= 5'h12)
        else $error("minimum mode lift above cap");
    max_cap_a: assert property (ctrl_out.bass_lift_db <= 5'h18
        && !ctrl_out.bass_lift_db[0])
        else $error("bass lift above cap or odd");
    emph_gate_a: assert property ($past(arst_n_in)
        |-> ctrl_out.emphasis_auto == ($past(op_mode_in) inside {4'h1, 4'h3})
        && ($past(op_mode_in) inside {[4'h4:4'h8]} || ctrl_out.emphasis_curve == 3'h0))
        else $error("emphasis not gated by mode");
    pin_mute_a: assert property ($past(silence_pin_in, 3) && $past(arst_n_in, 3)
        |-> ctrl_out.silence_active)
        else $error("mute pin did not silence");
    rate_narrow_a: assert property (ctrl_out.rate_narrow
        |-> !ctrl_out.rate_high && $past(op_mode_in) inside {4'h6, 4'h7})
        else $error("narrow range outside modes 6 and 7");
    src_excl_a: assert property ($onehot0({ctrl_out.data_from_spdif,
        ctrl_out.clock_from_xtal, ctrl_out.pll_ref_word_select}))
        else $error("source decode not exclusive");
    sign_path_a: assert property ($past(arst_n_in)
        |-> sample_out.valid == $past(sample_in.valid)
        && (sample_out.data == $past(sample_in.data)
        || sample_out.data == -$past(sample_in.data)))
        else $error("sample path corrupted");
    lock_gate_a: assert property (ctrl_out.lock |-> $past(spdif_lock_in))
        else $error("lock without raw lock");
endmodule

// ==== tb/adsc_regs_tb.sv ====
// self-checking bench for the sound control register bank
// assumes adsc_host drives writes; status pins are driven here
`timescale 1ns/1ps
module adsc_regs_tb;
    import adsc_pkg::*;
    logic clock_in, arst_n_in, pin, burst, lk, pcm;
    logic [3:0] op;
    logic [1:0] mode_o;
    logic [15:0] w12, w13, w14, w30;
    adsc_wr_t wr_b;
    adsc_sample_t smp_i, smp_o;
    adsc_ctrl_t ctrl;
    int miscompares, n_tests;
    adsc_host i_host (.clock_in(clock_in), .wr_out(wr_b));
    adsc_regs i_dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .wr_in(wr_b), .op_mode_in(op),
        .silence_pin_in(pin), .burst_detect_in(burst), .spdif_lock_in(lk), .pcm_detect_in(pcm),
        .sample_in(smp_i), .sound_mode_out(mode_o), .ctrl_out(ctrl), .sample_out(smp_o));
    function automatic adsc_ctrl_t exp_f();
        adsc_ctrl_t e;
        logic [4:0] b;
        b = {w12[11:8], 1'b0};
        e.bass_lift_db = w12[15:14] == 2'h1 ? (b > LIFT_CAP_MIN_DB ? LIFT_CAP_MIN_DB : b)
            : w12[15:14] == 2'h3 ? (b > LIFT_CAP_MAX_DB ? LIFT_CAP_MAX_DB : b) : 5'h0;
        e.fast_silence = w13[15];
        e.silence_active = w13[14] | pin | (w30[2] & burst);
        e.gain_6db = w13[13];
        e.emphasis_curve = op inside {[4'h4:4'h8]} ? w13[10:8] : 3'h0;
        e.emphasis_auto = op inside {4'h1, 4'h3};
        e.rate_high = w14[14];
        e.rate_narrow = !w14[14] && op inside {4'h6, 4'h7};
        e.data_from_spdif = w14[9:8] == 2'h2;
        e.clock_from_xtal = w14[9:8] == 2'h3;
        e.pll_ref_word_select = w14[9:8] == 2'h1;
        e.input_b = w30[0];
        e.lock = lk & (pcm | !w30[3]);
        return e;
    endfunction
    task automatic final_report();
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_c(input adsc_ctrl_t e);
        n_tests++;
        if (ctrl !== e) begin
            miscompares++;
            $display("[ERR] %0t ctrl %h exp %h", $time, ctrl, e);
        end
    endtask
    task automatic chk_m(input logic [1:0] e);
        n_tests++;
        if (mode_o !== e) begin
            miscompares++;
            $display("[ERR] %0t mode %h exp %h", $time, mode_o, e);
        end
    endtask
    task automatic chk_s(input adsc_sample_t e);
        n_tests++;
        if (smp_o !== e) begin
            miscompares++;
            $display("[ERR] %0t sample %h exp %h", $time, smp_o, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_host.wr(a, d);
        if (a == 8'h12) w12 = d;
        if (a == 8'h13) w13 = d;
        if (a == 8'h14) w14 = d;
        if (a == 8'h30) w30 = d;
    endtask
    // three edges covers the slowest path, the synced mute pin
    task automatic look();
        repeat (3) @(posedge clock_in);
        #1;
        chk_c(exp_f());
        chk_s('{smp_i.valid, w14[15] ? 24'hFFFEDD : 24'h000123});
        chk_m(w12[15:14]);
    endtask
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
    initial begin
        {arst_n_in, pin, burst, lk, pcm, op} = {5'h02, 4'h4};
        smp_i = '{1'b1, 24'h000123};
        {w12, w13, w14, w30} = {16'h0000, 16'h4000, 16'h4200, 16'h000C};
        repeat (4) @(posedge clock_in);
        #1;
        arst_n_in = 1'b1;
        look();
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 16; c++) begin
                wr(8'h12, {m[1:0], 2'h0, c[3:0], 8'h00});
                look();
            end
        end
        // quick mute follows the mode parity and gain its inverse so both levels are seen
        for (int o = 1; o < 9; o++) begin
            op = o[3:0];
            for (int e = 0; e < 4; e++) begin
                wr(8'h13, {o[0], 1'b0, ~o[0], 2'h0, e[2:0], 8'h00});
                look();
            end
        end
        op = 4'h6;
        for (int s = 0; s < 16; s++) begin
            smp_i.valid = s[0];
            wr(8'h14, {s[3], s[2], 4'h0, s[1:0], 8'h00});
            look();
        end
        for (int p = 0; p < 16; p++) begin
            {burst, pcm, lk} = {p[1], p[2], p != 15};
            wr(8'h30, {12'h000, p[3:2], 1'b0, p[0]});
            look();
        end
        wr(8'h15, 16'hFFFF);
        look();
        pin = 1'b1;
        look();
        pin = 1'b0;
        wr(8'h13, 16'h4000);
        look();
        final_report();
    end
endmodule
bind adsc_regs adsc_regs_chk i_chk (.clock_in(clock_in), .arst_n_in(arst_n_in), .wr_in(wr_in),
    .op_mode_in(op_mode_in), .silence_pin_in(silence_pin_in), .burst_detect_in(burst_detect_in),
    .spdif_lock_in(spdif_lock_in), .pcm_detect_in(pcm_detect_in), .sample_in(sample_in),
    .sound_mode_out(sound_mode_out), .ctrl_out(ctrl_out), .sample_out(sample_out));
